// ### pkg/ockb_pkg.sv
// Shared constants and types for the overlay colour key blend stage.
// Assumes one clock domain and a classic Wishbone register slave.
package ockb_pkg;
  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] KEY_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] CAPS_OFS = 8'h0C;
  // Control register fields.
  localparam int unsigned CTRL_KEY_EN_BIT = 0;
  localparam int unsigned CTRL_DST_BIT = 1;
  localparam int unsigned CTRL_ROT_BIT = 2;
  localparam int unsigned CTRL_ROPT_BIT = 3;
  localparam int unsigned CTRL_DUAL_BIT = 4;
  localparam int unsigned CTRL_FMT_LSB = 8;
  localparam int unsigned FMT_W = 5;
  // Capability and status register fields.
  localparam int unsigned CAPS_ROT_BIT = 16;
  localparam int unsigned CAPS_SCL_BIT = 17;
  localparam int unsigned CAPS_STR_LSB = 18;
  localparam int unsigned CAPS_HIT_BIT = 20;
  // Reset values.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [23:0] KEY_RST = 24'h00_0000;
  localparam logic [23:0] MASK_RST = 24'h00_0000;
  // Fetch rates in thousandths of a pixel per cycle.
  localparam logic [15:0] RATE_DUAL = 16'h0FA0;
  localparam logic [15:0] RATE_ONE = 16'h03E8;
  localparam logic [15:0] RATE_NORM = 16'h00C8;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } ockb_rgb_type;

  typedef struct packed {
    ockb_rgb_type iter;
    ockb_rgb_type ovl;
  } ockb_pair_type;

  typedef struct packed {
    ockb_rgb_type pix;
    ockb_pair_type pair;
    logic keyed;
    logic rop;
  } ockb_res_type;

  typedef struct packed {
    logic [15:0] burst;
    logic [15:0] opt;
    logic [15:0] norm;
    logic rot_ok;
    logic [1:0] streams;
  } ockb_cap_type;

  typedef enum logic [4:0] {
    FMT_CLUT1, FMT_CLUT2, FMT_CLUT4, FMT_CLUT8,
    FMT_RGB12, FMT_RGB16, FMT_RGB18, FMT_RGB18P,
    FMT_RGB19, FMT_RGB19P, FMT_RGB24, FMT_RGB24P,
    FMT_RGB25, FMT_RGB32, FMT_AYUV, FMT_YUV422,
    FMT_422SP, FMT_422PL, FMT_420SP, FMT_420PL
  } ockb_fmt_type;
endpackage

// ### hdl/ockb_top.sv
// Overlay colour combine stage: colour keying ahead of the alpha blender,
// plus the fetch capability table and the bus lock for rotation.
// Assumes pixels and fetch requests arrive on clk_i from local logic.
//
// Overview of operation
// - Stage takes iterated pixel, overlay pixel and configuration.
// - Source keying: masked overlay matches key, output iterated colour.
// - Destination keying: masked iterated matches key, output overlay.
// - Key target select zero picks source, one picks destination keying.
// - Keying acts only while colour key enable is one.
// - Separate red, green, blue key and mask; mask applied per component.
// - Zero mask disables the comparison and flags the raster operation.
// - Palette formats fetch 32, 16, 8, 4 pixels; scaling, no rotation.
// - Direct colour: 2, 1 or 1.333 per cycle; rotation normal 0.2.
// - Packed 18, 19, 24 bpp lack rotation optimization; all scale.
// - Rotation optimization locks the bus over consecutive single reads.
// - AYUV fetches 1 per cycle with rotation; packed 4:2:2 2, no rotation.
// - Semiplanar uses two streams, planar three.
// - One bus: 4:2:2 2, 4:2:0 2.66; two buses: 4 per cycle.
//
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module ockb_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pix_valid_i,
  input wire ockb_pkg::ockb_pair_type pix_i,
  output logic pix_valid_o,
  output ockb_pkg::ockb_res_type pix_o,
  input wire logic fetch_single_i,
  output logic fetch_lock_o,
  output logic [1:0] fetch_streams_o
);
  import ockb_pkg::*;

  logic [31:0] ctrl_q, ctrl_d;
  logic [23:0] key_q, key_d, mask_q, mask_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic hit_q, hit_d;
  logic pv_q, pv_d;
  ockb_res_type res_q, res_d;
  logic lock_q, lock_d;
  logic [1:0] str_q, str_d;
  ockb_fmt_type fmt;
  ockb_cap_type cap;
  logic key_en, key_dst, rot_en, ropt_en, dual;
  logic [15:0] rate;
  logic scale_ok;

  // Masked component compare; a clear mask bit never spoils a match.
  function automatic logic key_match(input ockb_rgb_type c,
                                     input logic [23:0] key,
                                     input logic [23:0] mask);
    key_match = ((c & mask) == (key & mask));
  endfunction

  // Fetch capability per format; rates in thousandths of pixels.
  function automatic ockb_cap_type cap_of(input ockb_fmt_type f,
                                          input logic two_bus);
    ockb_cap_type c;
    c = '{burst: RATE_ONE, opt: RATE_ONE, norm: RATE_NORM,
          rot_ok: 1'b1, streams: 2'h1};
    unique case (f)
      FMT_CLUT1, FMT_CLUT2, FMT_CLUT4, FMT_CLUT8: begin
        c.burst = 16'h7D00 >> (2'(f) + 16'h0);
        c.opt = 16'h0000;
        c.norm = 16'h0000;
        c.rot_ok = 1'b0;
      end
      FMT_RGB12, FMT_RGB16: begin
        c.burst = RATE_ONE << 1;
      end
      FMT_RGB18P, FMT_RGB19P, FMT_RGB24P: begin
        c.burst = 16'h0535;
        c.opt = 16'h0000;
        c.rot_ok = 1'b0;
      end
      FMT_YUV422: begin
        c.burst = RATE_ONE << 1;
        c.opt = 16'h0000;
        c.norm = 16'h0000;
        c.rot_ok = 1'b0;
      end
      FMT_422SP, FMT_422PL, FMT_420SP, FMT_420PL: begin
        c.streams = (f == FMT_422SP || f == FMT_420SP) ? 2'h2 : 2'h3;
        if (two_bus) begin
          c.burst = RATE_DUAL;
        end else begin
          unique case (f)
            FMT_422SP: begin
              c.burst = 16'h07D0;
              c.opt = 16'h0294;
              c.norm = 16'h0084;
            end
            FMT_422PL: begin
              c.burst = 16'h07D0;
              c.opt = 16'h01F4;
              c.norm = 16'h0064;
            end
            FMT_420SP: begin
              c.burst = 16'h0A64;
              c.opt = 16'h0320;
              c.norm = 16'h00A0;
            end
            default: begin
              c.burst = 16'h0A64;
              c.opt = 16'h0294;
              c.norm = 16'h0084;
            end
          endcase
        end
      end
      default: begin // Unpacked 18 to 32 bpp and AYUV.
      end
    endcase
    cap_of = c;
  endfunction

  assign key_en = ctrl_q[CTRL_KEY_EN_BIT];
  assign key_dst = ctrl_q[CTRL_DST_BIT];
  assign rot_en = ctrl_q[CTRL_ROT_BIT];
  assign ropt_en = ctrl_q[CTRL_ROPT_BIT];
  assign dual = ctrl_q[CTRL_DUAL_BIT];
  assign fmt = ockb_fmt_type'(ctrl_q[CTRL_FMT_LSB +: FMT_W]);
  assign cap = cap_of(fmt, dual);
  // Every listed format scales, so only a code past the table reads zero.
  assign scale_ok = (ctrl_q[CTRL_FMT_LSB +: FMT_W] <= 5'(FMT_420PL));

  always_comb begin
    if (!rot_en) begin
      rate = cap.burst;
    end else if (ropt_en && cap.rot_ok) begin
      rate = cap.opt;
    end else begin
      rate = cap.norm;
    end
  end

  // Register slave: ack one cycle after the request, write on the edge that ends the ack.
  always_comb begin
    ctrl_d = ctrl_q;
    key_d = key_q;
    mask_d = mask_q;
    dat_d = 32'h0000_0000;
    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
    if (ack_d) begin
      unique case (wb_adr_i)
        CTRL_OFS: dat_d = ctrl_q;
        KEY_OFS: dat_d = {8'h00, key_q};
        MASK_OFS: dat_d = {8'h00, mask_q};
        CAPS_OFS: dat_d = {11'h000, hit_q, cap.streams, scale_ok,
                           cap.rot_ok, rate};
        default: dat_d = 32'h0000_0000;
      endcase
    end
    if (wb_cyc_i && wb_stb_i && wb_we_i && ack_q) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel_i[i]) begin
          unique case (wb_adr_i)
            CTRL_OFS: ctrl_d[8*i +: 8] = wb_dat_i[8*i +: 8];
            KEY_OFS: if (i < 3) key_d[8*i +: 8] = wb_dat_i[8*i +: 8];
            MASK_OFS: if (i < 3) mask_d[8*i +: 8] = wb_dat_i[8*i +: 8];
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      key_q <= KEY_RST;
      mask_q <= MASK_RST;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      key_q <= key_d;
      mask_q <= mask_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // Pixel path: one register stage, no back-pressure.
  always_comb begin
    res_d = res_q;
    hit_d = hit_q;
    pv_d = pix_valid_i;
    if (pix_valid_i) begin
      res_d.pair = pix_i;
      res_d.pix = pix_i.ovl;
      res_d.keyed = 1'b0;
      res_d.rop = 1'b0;
      if (key_en) begin
        if (mask_q == 24'h00_0000) begin
          res_d.rop = 1'b1;
        end else if (!key_dst) begin
          res_d.keyed = 1'b1;
          if (key_match(pix_i.ovl, key_q, mask_q)) begin
            res_d.pix = pix_i.iter;
          end
        end else begin
          res_d.keyed = 1'b1;
          res_d.pix = pix_i.iter;
          if (key_match(pix_i.iter, key_q, mask_q)) begin
            res_d.pix = pix_i.ovl;
          end
        end
      end
      hit_d = res_d.keyed && (key_dst || key_match(pix_i.ovl, key_q, mask_q));
    end
  end

  // The lock covers only single accesses while the format allows it.
  always_comb begin
    lock_d = fetch_single_i && rot_en && ropt_en && cap.rot_ok;
    str_d = cap.streams;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pv_q <= 1'b0;
      res_q <= '0;
      hit_q <= 1'b0;
      lock_q <= 1'b0;
      str_q <= 2'h1;
    end else begin
      pv_q <= pv_d;
      res_q <= res_d;
      hit_q <= hit_d;
      lock_q <= lock_d;
      str_q <= str_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign pix_valid_o = pv_q;
  assign pix_o = res_q;
  assign fetch_lock_o = lock_q;
  assign fetch_streams_o = str_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  bus_ack_pulse_a: assert property (
    wb_cyc_i && wb_stb_i && !ack_q |=> ack_q ##1 !ack_q)
    else $error("Bus ack not a single pulse after request.");

  src_key_a: assert property (
    pix_valid_i && key_en && !key_dst && mask_q != 24'h00_0000 &&
    key_match(pix_i.ovl, key_q, mask_q)
    |=> pix_valid_o && pix_o.keyed && pix_o.pix == $past(pix_i.iter))
    else $error("Source key match did not select iterated colour.");

  dst_key_a: assert property (
    pix_valid_i && key_en && key_dst && mask_q != 24'h00_0000
    |=> pix_o.pix == ($past(key_match(pix_i.iter, key_q, mask_q)) ?
        $past(pix_i.ovl) : $past(pix_i.iter)))
    else $error("Destination keying picked the wrong colour.");

  key_off_a: assert property (
    pix_valid_i && !key_en
    |=> !pix_o.keyed && !pix_o.rop && pix_o.pair == $past(pix_i))
    else $error("Keying acted while disabled.");

  rop_mask_a: assert property (
    pix_valid_i && key_en && mask_q == 24'h00_0000
    |=> pix_o.rop && !pix_o.keyed)
    else $error("Zero mask did not select raster operation.");

  clut_rate_a: assert property (
    fmt == FMT_CLUT4 && !rot_en |-> rate == 16'h1F40 && !cap.rot_ok)
    else $error("Palette 4 bpp fetch rate wrong.");

  packed_lock_a: assert property (
    fmt inside {FMT_RGB18P, FMT_RGB19P, FMT_RGB24P, FMT_YUV422}
    ##1 fmt == $past(fmt) |-> !fetch_lock_o)
    else $error("Bus lock raised for a format without rotation.");

  lock_follow_a: assert property (
    fetch_single_i && rot_en && ropt_en && fmt == FMT_RGB32
    |=> fetch_lock_o)
    else $error("Bus lock missing on single access.");

  streams_a: assert property (
    fmt == FMT_420PL && !dual && !rot_en
    |=> fetch_streams_o == 2'h3 ##0 $past(rate) == 16'h0A64)
    else $error("Planar stream count or rate wrong.");
endmodule
`default_nettype wire

// ### test/ockb_fetch_model.sv
// Fetch engine model on the memory side of the stage.
// Assumes clk_i and a synchronous active-high rst_i from the bench.
`timescale 1ns/1ps
`default_nettype none
module ockb_fetch_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic fetch_single_o
);
  logic [1:0] cnt_q;
  // Runs of three consecutive single accesses with a gap, so the lock is
  // seen both held across a run and dropped between runs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 2'h0;
      fetch_single_o <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      fetch_single_o <= run_i && cnt_q != 2'h3;
    end
  end
endmodule
`default_nettype wire

// ### test/ockb_top_tb.sv
// Self-checking bench for the colour key stage and its fetch table.
// Assumes the Wishbone slave answers in one cycle, as handed over.
`timescale 1ns/1ps
`default_nettype none
module ockb_top_tb;
  import ockb_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat = 32'h0, wdo, q;
  logic ack, pv = 1'b0, pvo, single, lock, run = 1'b0, ps;
  logic [1:0] st;
  ockb_pair_type pin = '0;
  ockb_res_type pout;
  logic [23:0] k, m, it, ov, ep;
  logic eh;
  logic [3:0] ctl;
  int n_errors = 0, checks = 0;
  int rt [4][3] = '{'{13, 1000, 1}, '{11, 200, 0}, '{15, 0, 0},
    '{18, 800, 1}};
  always #5 clk = ~clk;
  ockb_top DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(wdo), .wb_ack_o(ack), .pix_valid_i(pv), .pix_i(pin),
    .pix_valid_o(pvo), .pix_o(pout), .fetch_single_i(single),
    .fetch_lock_o(lock), .fetch_streams_o(st));
  ockb_fetch_model model (.clk_i(clk), .rst_i(rst), .run_i(run),
    .fetch_single_o(single));
  task automatic chk(input string nm, input logic [75:0] e,
    input logic [75:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk("ack", 1, 0);
    q = wdo;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [15:0] burst(input int f, input logic dual);
    case (f)
      0: return 16'h7D00;
      1: return 16'h3E80;
      2: return 16'h1F40;
      3: return 16'h0FA0;
      4, 5, 15: return 16'h07D0;
      7, 9, 11: return 16'h0535;
      16, 17: return dual ? 16'h0FA0 : 16'h07D0;
      18, 19: return dual ? 16'h0FA0 : 16'h0A64;
      default: return 16'h03E8;
    endcase
  endfunction
  function automatic logic [3:0] caps_hi(input int f);
    logic [1:0] s;
    s = (f == 16 || f == 18) ? 2'h2 : (f == 17 || f == 19) ? 2'h3 : 2'h1;
    return {s, 1'b1, !(f < 4 || f inside {7, 9, 11, 15})};
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    complete_run();
  end
  initial begin
    void'($urandom(66049));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("streams", 1, st);
    for (int a = 0; a < 20; a += 4) begin
      wb(1'b0, a[7:0], 32'h0);
      chk("reset word", (a == 12) ? {12'h000, caps_hi(0), burst(0, 1'b0)}
        : 32'h0, q);
    end
    $display("reset test done");
    for (int i = 0; i < 60; i++) begin
      k = $urandom; m = (i % 5 == 0) ? 24'h0 : $urandom;
      ctl = $urandom % 4; it = $urandom; ov = $urandom;
      if (i % 2 == 1) begin
        if (ctl[1]) it = (k & m) | (it & ~m);
        else ov = (k & m) | (ov & ~m);
      end
      wb(1'b1, CTRL_OFS, {28'h0, ctl});
      wb(1'b1, KEY_OFS, {8'hA5, k});
      wb(1'b0, KEY_OFS, 32'h0);
      chk("key", {8'h00, k}, q);
      wb(1'b1, MASK_OFS, {8'h00, m});
      if (!ctl[0] || m == 24'h0) ep = ov;
      else if (!ctl[1]) ep = ((ov & m) == (k & m)) ? it : ov;
      else ep = ((it & m) == (k & m)) ? ov : it;
      eh = ctl[0] && m != 24'h0 && (ctl[1] || (ov & m) == (k & m));
      pv <= 1'b1; pin <= {it, ov};
      @(posedge clk);
      pv <= 1'b0;
      @(negedge clk);
      chk("valid", 1, pvo);
      chk("pixel", {ep, it, ov, ctl[0] && m != 24'h0, ctl[0] && m == 24'h0},
        {pout.pix, pout.pair, pout.keyed, pout.rop});
      @(posedge clk);
      wb(1'b0, CAPS_OFS, 32'h0);
      chk("hit", eh, q[CAPS_HIT_BIT]);
    end
    $display("keying test done");
    for (int f = 0; f < 20; f++) begin
      wb(1'b1, CTRL_OFS, {19'h0, f[4:0], 3'h0, f[0] ^ f[1], 4'h0});
      wb(1'b0, CAPS_OFS, 32'h0);
      chk("caps", {caps_hi(f), burst(f, f[0] ^ f[1])},
        q[19:0]);
      chk("streams out", caps_hi(f) >> 2, st);
    end
    $display("format test done");
    for (int r = 0; r < 4; r++) begin
      wb(1'b1, CTRL_OFS, {19'h0, rt[r][0][4:0], 8'h0C});
      wb(1'b0, CAPS_OFS, 32'h0);
      chk("rot rate", rt[r][1], q[15:0]);
      run <= 1'b1; ps = 1'b0;
      repeat (12) begin
        @(negedge clk);
        chk("lock", ps & rt[r][2][0], lock);
        ps = single;
      end
      @(posedge clk);
      run <= 1'b0;
      @(posedge clk);
    end
    $display("rotation test done");
    complete_run();
  end
endmodule
`default_nettype wire
